//--- hdl/rtp_defs.vh
// Constants for the temperature protection block: register map,
// field positions, reset values and sizes.
// Assumes inclusion by bare name from every design file.
`ifndef RTP_DEFS_VH
`define RTP_DEFS_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define RTP_NCH        11
`define RTP_NGRP       4
`define RTP_NUNIT      15
`define RTP_TW         16
`define RTP_CHW        4
`define RTP_DLYW       32

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RTP_OFF_CTRL      12'h000
`define RTP_OFF_UNIT_EN   12'h004
`define RTP_OFF_ALM_EN    12'h008
`define RTP_OFF_DELAY     12'h00C
`define RTP_OFF_VOTE      12'h010
`define RTP_OFF_VSEL0     12'h014
`define RTP_OFF_VSEL1     12'h018
`define RTP_OFF_TRIP_ST   12'h01C
`define RTP_OFF_ALM_ST    12'h020
`define RTP_OFF_TMO_ST    12'h024
`define RTP_OFF_COLL_ST   12'h028
`define RTP_OFF_IRQ_ST    12'h02C
`define RTP_OFF_IRQ_MASK  12'h030
`define RTP_OFF_TRIP_THR  12'h040
`define RTP_OFF_ALM_THR   12'h080
`define RTP_THR_SPAN      12'h03C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTP_CTRL_EN       0
`define RTP_CTRL_SRC      1
`define RTP_VOTE_ACT0     0
`define RTP_VOTE_ACT1     1
`define RTP_VOTE_N0_LO    8
`define RTP_VOTE_N1_LO    12
`define RTP_IRQ_ALM       0
`define RTP_IRQ_TMO       1
`define RTP_IRQ_TRIP      2
`define RTP_NIRQ          3

// ----------------------------------------------------------------
// Reset values and hysteresis factors
// ----------------------------------------------------------------
`define RTP_RST_DELAY     32'h0000_03E8
`define RTP_RST_THR       16'hFFFF
`define RTP_HYST_NUM      8'h63
`define RTP_HYST_DEN      8'h64

`endif

//--- hdl/rtp_unit.v
// One protection unit: undelayed trip and delayed alarm with
// hysteresis on a single temperature. Used for channels and groups.
// Assumes temperature and settings are synchronous to pclk.
`timescale 1ns/1ps
`include "rtp_defs.vh"

module rtp_unit (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   enable,
  input  wire                   alarm_enable,
  input  wire [`RTP_TW-1:0]     temp,
  input  wire [`RTP_TW-1:0]     trip_thr,
  input  wire [`RTP_TW-1:0]     alarm_thr,
  input  wire [`RTP_DLYW-1:0]   delay,
  output reg                    trip_reg,
  output reg                    alarm_reg,
  output reg                    timeout_reg
);

  reg  [`RTP_DLYW-1:0] cnt_reg;
  wire [23:0]          temp_x100;
  wire [23:0]          trip_x99;
  wire [23:0]          alarm_x99;
  wire                 alm_on;
  wire                 alm_hold;

  // ----------------------------------------------------------------
  // Dropout levels scaled to avoid division
  // ----------------------------------------------------------------
  assign temp_x100 = temp * `RTP_HYST_DEN;
  assign trip_x99  = trip_thr * `RTP_HYST_NUM;
  assign alarm_x99 = alarm_thr * `RTP_HYST_NUM;
  assign alm_on    = enable & alarm_enable;
  // Alarm still up after this edge; timeout must fall with it
  assign alm_hold  = alm_on & ((temp > alarm_thr) |
                               (temp_x100 >= alarm_x99));

  // Trip picks up over threshold, drops below 0.99 of it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_reg <= 1'b0;
    end else if (!enable) begin
      trip_reg <= 1'b0;
    end else if (temp > trip_thr) begin
      trip_reg <= 1'b1;
    end else if (temp_x100 < trip_x99) begin
      trip_reg <= 1'b0;
    end
  end

  // Alarm pickup with hysteresis
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_reg <= 1'b0;
    end else if (!alm_on) begin
      alarm_reg <= 1'b0;
    end else if (temp > alarm_thr) begin
      alarm_reg <= 1'b1;
    end else if (temp_x100 < alarm_x99) begin
      alarm_reg <= 1'b0;
    end
  end

  // Delay counter runs while the alarm is picked up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg     <= {`RTP_DLYW{1'b0}};
      timeout_reg <= 1'b0;
    end else if (!alarm_reg || !alm_hold) begin
      cnt_reg     <= {`RTP_DLYW{1'b0}};
      timeout_reg <= 1'b0;
    end else if (cnt_reg >= delay) begin
      timeout_reg <= 1'b1;
    end else begin
      cnt_reg     <= cnt_reg + 1'b1;
    end
  end

endmodule // rtp_unit

//--- hdl/rtp_top.v
// Temperature protection: eleven channels, four hottest-sensor
// groups, two voting schemes, collective signals and trip source.
// Assumes readings arrive as a strobe, channel index and value on
// pclk; block_trip_cmd comes from logic on the same clock.
`timescale 1ns/1ps
`include "rtp_defs.vh"

// Contract
// - Eleven channels processed independently
// - Undelayed trip, delayed alarm per channel
// - Trip uses only its threshold
// - Alarm has own threshold and enable
// - Dropout below 0.99 of threshold
// - Global and per-channel enables gate everything
// - Groups decide on hottest channel
// - Inactive voting scheme never trips
// - Vote trips when count reaches setting
// - Votes need channel and function active
// - Voting trip used only if selected
// - Collective OR of channels' and groups' signals
// - Collective timeout ORs sensors and groups
// - Final trip chosen by source select
// - Block command suppresses all trips
module rtp_top (
  input  wire               pclk,
  input  wire               presetn,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  output wire               pready,
  output wire               pslverr,
  output reg  [31:0]        prdata,
  input  wire               temp_valid,
  input  wire [`RTP_CHW-1:0] temp_chan,
  input  wire [`RTP_TW-1:0] temp_data,
  input  wire               block_trip_cmd,
  output reg                all_groups_alarm,
  output reg                all_groups_timeout,
  output reg                all_groups_trip,
  output reg                collective_timeout,
  output reg  [1:0]         vote_trip,
  output reg                final_trip,
  output wire               irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [`RTP_TW-1:0]     temp_mem [0:`RTP_NCH-1];
  reg  [`RTP_TW-1:0]     trip_thr_mem [0:`RTP_NUNIT-1];
  reg  [`RTP_TW-1:0]     alm_thr_mem  [0:`RTP_NUNIT-1];
  reg                    glob_en_reg;
  reg                    trip_source_select;
  reg  [`RTP_NUNIT-1:0]  unit_en_reg;
  reg  [`RTP_NUNIT-1:0]  alm_en_reg;
  reg  [`RTP_DLYW-1:0]   delay_reg;
  reg  [1:0]             vote_act_reg;
  reg  [`RTP_CHW-1:0]    vote_n0_reg;
  reg  [`RTP_CHW-1:0]    vote_n1_reg;
  reg  [`RTP_NCH-1:0]    vsel0_reg;
  reg  [`RTP_NCH-1:0]    vsel1_reg;
  reg  [`RTP_NIRQ-1:0]   irq_st_reg;
  reg  [`RTP_NIRQ-1:0]   irq_mask_reg;
  reg  [`RTP_NIRQ-1:0]   ev_prev_reg;

  wire [`RTP_NUNIT-1:0]  u_trip;
  wire [`RTP_NUNIT-1:0]  u_alarm;
  wire [`RTP_NUNIT-1:0]  u_tmo;
  wire [`RTP_NUNIT*`RTP_TW-1:0] u_temp;
  wire [`RTP_NCH-1:0]    ch_trip;
  wire [`RTP_NUNIT-1:0]  trip_out;
  wire                   wr_en;
  wire                   rd_en;
  wire                   thr_trip_hit;
  wire                   thr_alm_hit;
  wire [11:0]            thr_trip_off;
  wire [11:0]            thr_alm_off;
  wire [3:0]             thr_trip_idx;
  wire [3:0]             thr_alm_idx;
  wire [3:0]             cnt0;
  wire [3:0]             cnt1;
  wire [1:0]             vote_next;
  wire [`RTP_NIRQ-1:0]   ev_now;
  wire [`RTP_NIRQ-1:0]   ev_rise;
  reg                    mapped;
  reg  [31:0]            rdata;
  integer                i;
  integer                j;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Hottest enabled channel temperature within a range
  function [`RTP_TW-1:0] hottest;
    input [`RTP_NCH*`RTP_TW-1:0] temps;
    input [`RTP_NCH-1:0]         en;
    input [3:0]                  lo;
    input [3:0]                  hi;
    integer k;
    begin
      hottest = {`RTP_TW{1'b0}};
      for (k = 0; k < `RTP_NCH; k = k + 1) begin
        if (k >= lo && k <= hi && en[k] &&
            temps[k*`RTP_TW +: `RTP_TW] > hottest) begin
          hottest = temps[k*`RTP_TW +: `RTP_TW];
        end
      end
    end
  endfunction

  // Number of set bits among selected channels
  function [3:0] count_sel;
    input [`RTP_NCH-1:0] hits;
    input [`RTP_NCH-1:0] sel;
    integer k;
    begin
      count_sel = 4'h0;
      for (k = 0; k < `RTP_NCH; k = k + 1) begin
        if (hits[k] && sel[k]) begin
          count_sel = count_sel + 4'h1;
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Latest reading per channel
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `RTP_NCH; i = i + 1) begin
        temp_mem[i] <= {`RTP_TW{1'b0}};
      end
    end else if (temp_valid && temp_chan < `RTP_NCH) begin
      temp_mem[temp_chan] <= temp_data;
    end
  end

  // ----------------------------------------------------------------
  // Protection units: channels then groups
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `RTP_NCH; g = g + 1) begin : g_ch
      assign u_temp[g*`RTP_TW +: `RTP_TW] = temp_mem[g];
    end
  endgenerate

  // Group temperature is the hottest enabled member
  assign u_temp[11*`RTP_TW +: `RTP_TW] =
    hottest(u_temp[`RTP_NCH*`RTP_TW-1:0],
            unit_en_reg[`RTP_NCH-1:0], 4'h0, 4'h2);
  assign u_temp[12*`RTP_TW +: `RTP_TW] =
    hottest(u_temp[`RTP_NCH*`RTP_TW-1:0],
            unit_en_reg[`RTP_NCH-1:0], 4'h3, 4'h5);
  assign u_temp[13*`RTP_TW +: `RTP_TW] =
    hottest(u_temp[`RTP_NCH*`RTP_TW-1:0],
            unit_en_reg[`RTP_NCH-1:0], 4'h6, 4'h7);
  assign u_temp[14*`RTP_TW +: `RTP_TW] =
    hottest(u_temp[`RTP_NCH*`RTP_TW-1:0],
            unit_en_reg[`RTP_NCH-1:0], 4'h8, 4'hA);

  generate
    for (g = 0; g < `RTP_NUNIT; g = g + 1) begin : g_unit
      rtp_unit u_unit (
        .pclk         (pclk),
        .presetn      (presetn),
        .enable       (glob_en_reg & unit_en_reg[g]),
        .alarm_enable (alm_en_reg[g]),
        .temp         (u_temp[g*`RTP_TW +: `RTP_TW]),
        .trip_thr     (trip_thr_mem[g]),
        .alarm_thr    (alm_thr_mem[g]),
        .delay        (delay_reg),
        .trip_reg     (u_trip[g]),
        .alarm_reg    (u_alarm[g]),
        .timeout_reg  (u_tmo[g])
      );
    end
  endgenerate

  // Block command masks every unit trip
  assign trip_out = u_trip & {`RTP_NUNIT{~block_trip_cmd}};
  assign ch_trip  = u_trip[`RTP_NCH-1:0];

  // ----------------------------------------------------------------
  // Voting
  // ----------------------------------------------------------------
  // Unit trip already zero for inactive channel or function
  assign cnt0 = count_sel(ch_trip, vsel0_reg);
  assign cnt1 = count_sel(ch_trip, vsel1_reg);
  assign vote_next[0] = vote_act_reg[0] &&
                        vote_n0_reg != 4'h0 &&
                        cnt0 >= vote_n0_reg;
  assign vote_next[1] = vote_act_reg[1] &&
                        vote_n1_reg != 4'h0 &&
                        cnt1 >= vote_n1_reg;

  // ----------------------------------------------------------------
  // Collective outputs
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      all_groups_alarm   <= 1'b0;
      all_groups_timeout <= 1'b0;
      all_groups_trip    <= 1'b0;
      collective_timeout <= 1'b0;
      vote_trip          <= 2'h0;
      final_trip         <= 1'b0;
    end else begin
      all_groups_alarm   <= |u_alarm;
      all_groups_timeout <= |u_tmo;
      all_groups_trip    <= |trip_out;
      collective_timeout <= |u_tmo;
      vote_trip <= vote_next & {2{~block_trip_cmd}};
      if (block_trip_cmd) begin
        final_trip <= 1'b0;
      end else if (trip_source_select) begin
        final_trip <= |vote_next;
      end else begin
        final_trip <= |trip_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts on rising collective events
  // ----------------------------------------------------------------
  assign ev_now  = {final_trip, collective_timeout, all_groups_alarm};
  assign ev_rise = ev_now & ~ev_prev_reg;
  assign irq     = |(irq_st_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_en        = psel & penable & pwrite;
  assign rd_en        = psel & ~pwrite;
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~mapped;
  assign thr_trip_off = paddr - `RTP_OFF_TRIP_THR;
  assign thr_alm_off  = paddr - `RTP_OFF_ALM_THR;
  assign thr_trip_idx = thr_trip_off[5:2];
  assign thr_alm_idx  = thr_alm_off[5:2];
  assign thr_trip_hit = paddr >= `RTP_OFF_TRIP_THR &&
                        thr_trip_off <= `RTP_THR_SPAN &&
                        thr_trip_off[1:0] == 2'h0;
  assign thr_alm_hit  = paddr >= `RTP_OFF_ALM_THR &&
                        thr_alm_off <= `RTP_THR_SPAN &&
                        thr_alm_off[1:0] == 2'h0;

  // Read mux and address map check
  always @* begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `RTP_OFF_CTRL: begin
        rdata[`RTP_CTRL_EN]  = glob_en_reg;
        rdata[`RTP_CTRL_SRC] = trip_source_select;
      end
      `RTP_OFF_UNIT_EN:  rdata[`RTP_NUNIT-1:0] = unit_en_reg;
      `RTP_OFF_ALM_EN:   rdata[`RTP_NUNIT-1:0] = alm_en_reg;
      `RTP_OFF_DELAY:    rdata = delay_reg;
      `RTP_OFF_VOTE: begin
        rdata[1:0] = vote_act_reg;
        rdata[`RTP_VOTE_N0_LO +: `RTP_CHW] = vote_n0_reg;
        rdata[`RTP_VOTE_N1_LO +: `RTP_CHW] = vote_n1_reg;
      end
      `RTP_OFF_VSEL0:    rdata[`RTP_NCH-1:0] = vsel0_reg;
      `RTP_OFF_VSEL1:    rdata[`RTP_NCH-1:0] = vsel1_reg;
      `RTP_OFF_TRIP_ST:  rdata[`RTP_NUNIT-1:0] = trip_out;
      `RTP_OFF_ALM_ST:   rdata[`RTP_NUNIT-1:0] = u_alarm;
      `RTP_OFF_TMO_ST:   rdata[`RTP_NUNIT-1:0] = u_tmo;
      `RTP_OFF_COLL_ST: begin
        rdata[5:0] = {vote_trip, final_trip, all_groups_trip,
                      all_groups_timeout, all_groups_alarm};
      end
      `RTP_OFF_IRQ_ST:   rdata[`RTP_NIRQ-1:0] = irq_st_reg;
      `RTP_OFF_IRQ_MASK: rdata[`RTP_NIRQ-1:0] = irq_mask_reg;
      default: begin
        if (thr_trip_hit) begin
          rdata[`RTP_TW-1:0] = trip_thr_mem[thr_trip_idx];
        end else if (thr_alm_hit) begin
          rdata[`RTP_TW-1:0] = alm_thr_mem[thr_alm_idx];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // Read data captured in the setup cycle, held for the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata <= rdata;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glob_en_reg        <= 1'b0;
      trip_source_select <= 1'b0;
      unit_en_reg        <= {`RTP_NUNIT{1'b0}};
      alm_en_reg         <= {`RTP_NUNIT{1'b0}};
      delay_reg          <= `RTP_RST_DELAY;
      vote_act_reg       <= 2'h0;
      vote_n0_reg        <= {`RTP_CHW{1'b0}};
      vote_n1_reg        <= {`RTP_CHW{1'b0}};
      vsel0_reg          <= {`RTP_NCH{1'b0}};
      vsel1_reg          <= {`RTP_NCH{1'b0}};
      irq_mask_reg       <= {`RTP_NIRQ{1'b0}};
      for (j = 0; j < `RTP_NUNIT; j = j + 1) begin
        trip_thr_mem[j] <= `RTP_RST_THR;
        alm_thr_mem[j]  <= `RTP_RST_THR;
      end
    end else if (wr_en) begin
      case (paddr)
        `RTP_OFF_CTRL: begin
          glob_en_reg        <= pwdata[`RTP_CTRL_EN];
          trip_source_select <= pwdata[`RTP_CTRL_SRC];
        end
        `RTP_OFF_UNIT_EN:  unit_en_reg <= pwdata[`RTP_NUNIT-1:0];
        `RTP_OFF_ALM_EN:   alm_en_reg  <= pwdata[`RTP_NUNIT-1:0];
        `RTP_OFF_DELAY:    delay_reg   <= pwdata;
        `RTP_OFF_VOTE: begin
          vote_act_reg <= pwdata[1:0];
          vote_n0_reg  <= pwdata[`RTP_VOTE_N0_LO +: `RTP_CHW];
          vote_n1_reg  <= pwdata[`RTP_VOTE_N1_LO +: `RTP_CHW];
        end
        `RTP_OFF_VSEL0:    vsel0_reg <= pwdata[`RTP_NCH-1:0];
        `RTP_OFF_VSEL1:    vsel1_reg <= pwdata[`RTP_NCH-1:0];
        `RTP_OFF_IRQ_MASK: irq_mask_reg <= pwdata[`RTP_NIRQ-1:0];
        default: begin
          if (thr_trip_hit) begin
            trip_thr_mem[thr_trip_idx] <= pwdata[`RTP_TW-1:0];
          end else if (thr_alm_hit) begin
            alm_thr_mem[thr_alm_idx] <= pwdata[`RTP_TW-1:0];
          end
        end
      endcase
    end
  end

  // Sticky status, write one to clear, new event wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg  <= {`RTP_NIRQ{1'b0}};
      ev_prev_reg <= {`RTP_NIRQ{1'b0}};
    end else begin
      ev_prev_reg <= ev_now;
      if (wr_en && paddr == `RTP_OFF_IRQ_ST) begin
        irq_st_reg <= (irq_st_reg & ~pwdata[`RTP_NIRQ-1:0]) | ev_rise;
      end else begin
        irq_st_reg <= irq_st_reg | ev_rise;
      end
    end
  end

endmodule // rtp_top

//--- tb/rtp_props.sv
// Checker on the ports of the temperature protection top.
// Assumes one pclk domain and reset presetn, active low.
`timescale 1ns/1ps
module rtp_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pslverr,
  input wire        block_trip_cmd,
  input wire        all_groups_alarm,
  input wire        all_groups_timeout,
  input wire        all_groups_trip,
  input wire        collective_timeout,
  input wire [1:0]  vote_trip,
  input wire        final_trip
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Block held long enough to pass the output pipeline
  sequence s_blocked;
    block_trip_cmd [*3];
  endsequence
  // First cycle of a collective timeout
  sequence s_tmo_rise;
    !all_groups_timeout ##1 all_groups_timeout;
  endsequence
  a_block_trips: assert property (
    s_blocked |-> !final_trip && !all_groups_trip && vote_trip == 2'h0)
    else $error("trip seen while blocked");
  a_final_source: assert property (
    final_trip |-> all_groups_trip || vote_trip != 2'h0)
    else $error("final trip without a source");
  a_vote_cause: assert property (
    vote_trip != 2'h0 |-> all_groups_trip)
    else $error("vote trip without a channel trip");
  a_coll_timeout: assert property (
    collective_timeout == all_groups_timeout)
    else $error("collective timeout differs");
  a_timeout_alarm: assert property (
    all_groups_timeout |-> all_groups_alarm)
    else $error("timeout without alarm");
  a_alarm_first: assert property (
    s_tmo_rise |-> $past(all_groups_alarm))
    else $error("timeout rose before alarm");
  a_unmapped_err: assert property (
    psel && penable && paddr >= 12'h0C0 |-> pslverr)
    else $error("no error on unmapped access");
  a_err_access: assert property (
    pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule // rtp_props

bind rtp_top rtp_props chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .block_trip_cmd(block_trip_cmd),
  .all_groups_alarm(all_groups_alarm),
  .all_groups_timeout(all_groups_timeout),
  .all_groups_trip(all_groups_trip),
  .collective_timeout(collective_timeout),
  .vote_trip(vote_trip), .final_trip(final_trip));

//--- tb/rtp_sensor_model.sv
// Model of the remote temperature detector: scans the channels.
// Assumes the bench loads temp_mem by hierarchical reference.
`timescale 1ns/1ps
module rtp_sensor_model #(
  parameter GAP = 1
) (
  input  wire        pclk,
  input  wire        presetn,
  output reg         temp_valid,
  output reg  [3:0]  temp_chan,
  output reg  [15:0] temp_data
);
  reg  [15:0] temp_mem [0:10];
  reg  [7:0]  gap_cnt;
  wire [3:0]  nxt = (temp_chan >= 4'hA) ? 4'h0 : temp_chan + 4'h1;
  // One reading per GAP+1 cycles, eleven channels in turn
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_valid <= 1'b0;
      temp_chan  <= 4'hF;
      temp_data  <= 16'h0000;
      gap_cnt    <= 8'h00;
    end else if (gap_cnt != 8'h00) begin
      temp_valid <= 1'b0;
      temp_data  <= ~temp_data; // Inverted last value between readings, no stale value
      gap_cnt    <= gap_cnt - 8'h01;
    end else begin
      temp_valid <= 1'b1;
      temp_chan  <= nxt;
      temp_data  <= temp_mem[nxt];
      gap_cnt    <= 8'(GAP);
    end
  end
endmodule // rtp_sensor_model

//--- tb/testbench.sv
// Self-checking bench for the temperature protection top.
// Assumes rtp_top, the sensor model and the bound checker.
`timescale 1ns/1ps
module testbench;
  reg         pclk, presetn, psel, penable, pwrite, block_trip_cmd;
  reg  [11:0] paddr, a;
  reg  [31:0] pwdata, rv;
  reg         ev;
  wire        pready, pslverr, temp_valid, irq;
  wire        all_groups_alarm, all_groups_timeout, all_groups_trip;
  wire        collective_timeout, final_trip;
  wire [1:0]  vote_trip;
  wire [31:0] prdata;
  wire [3:0]  temp_chan;
  wire [15:0] temp_data;
  integer     num_errors, total_checks, cyc, i;

  rtp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .temp_valid(temp_valid), .temp_chan(temp_chan),
    .temp_data(temp_data), .block_trip_cmd(block_trip_cmd),
    .all_groups_alarm(all_groups_alarm),
    .all_groups_timeout(all_groups_timeout),
    .all_groups_trip(all_groups_trip),
    .collective_timeout(collective_timeout), .vote_trip(vote_trip),
    .final_trip(final_trip), .irq(irq));
  rtp_sensor_model #(.GAP(1)) model_u (.pclk(pclk), .presetn(presetn),
    .temp_valid(temp_valid), .temp_chan(temp_chan),
    .temp_data(temp_data));

  always #5 pclk = ~pclk;
  // Watchdog against a hung handshake
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end

  task chk(input string nm, input [31:0] ex, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== ex) begin
        num_errors = num_errors + 1;
        $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  // One APB transfer, held until pready at a rising edge
  task apb(input [11:0] ad, input w, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] ad, input [31:0] d);
    apb(ad, 1'b1, d);
  endtask
  task rdc(input string nm, input [11:0] ad, input [31:0] ex);
    begin
      apb(ad, 1'b0, 32'h0);
      chk(nm, ex, rv);
      chk("pslverr", 32'h0, ev);
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge pclk);
  endtask
  task st(input integer ch, input [15:0] v);
    model_u.temp_mem[ch] = v;
  endtask
  task blk(input v);
    begin
      @(posedge pclk);
      block_trip_cmd <= v;
      wt(5);
    end
  endtask

  task t_reset;
    begin
      rdc("ctrl", 12'h000, 32'h0);
      rdc("delay", 12'h00C, 32'h3E8);
      rdc("trip_thr", 12'h040, 32'hFFFF);
      rdc("alarm_thr", 12'h0B8, 32'hFFFF);
      apb(12'h0C0, 1'b0, 32'h0);
      chk("unmapped_data", 32'h0, rv);
      chk("unmapped_err", 32'h1, ev);
      wr(12'h01C, 32'hFFFF);
      rdc("trip_st", 12'h01C, 32'h0);
      $display("test reset done");
    end
  endtask
  task t_trip;
    begin
      wr(12'h000, 32'h1);
      wr(12'h004, 32'h7FFF);
      wr(12'h008, 32'h7FFF);
      wr(12'h00C, 32'h5);
      for (a = 12'h040; a < 12'h07C; a = a + 12'h004) begin
        wr(a, 32'h64);
        wr(a + 12'h040, 32'h50);
      end
      st(3, 16'h0065);
      wt(30);
      chk("trip", 32'h1, all_groups_trip);
      chk("final", 32'h1, final_trip);
      chk("alarm", 32'h1, all_groups_alarm);
      rdc("trip_st", 12'h01C, 32'h1008);
      wt(15);
      rdc("tmo_st", 12'h024, 32'h1008);
      chk("coll_tmo", 32'h1, collective_timeout);
      chk("tmo", 32'h1, all_groups_timeout);
      wr(12'h008, 32'h6FF7);
      wt(5);
      chk("alarm", 32'h0, all_groups_alarm);
      chk("trip", 32'h1, all_groups_trip);
      st(3, 16'h0032);
      wr(12'h008, 32'h7FFF);
      wt(30);
      $display("test trip done");
    end
  endtask
  task t_hyst;
    begin
      st(0, 16'h0064);
      wt(30);
      chk("trip", 32'h0, all_groups_trip);
      st(0, 16'h0065);
      wt(30);
      chk("trip", 32'h1, all_groups_trip);
      st(0, 16'h0063);
      wt(30);
      chk("trip", 32'h1, all_groups_trip);
      st(0, 16'h0062);
      wt(30);
      chk("trip", 32'h0, all_groups_trip);
      $display("test hysteresis done");
    end
  endtask
  task t_enable;
    begin
      st(0, 16'h0065);
      wt(30);
      wr(12'h004, 32'h7FFE);
      wt(5);
      chk("trip", 32'h0, all_groups_trip);
      wr(12'h004, 32'h7FFF);
      wt(5);
      chk("trip", 32'h1, all_groups_trip);
      wr(12'h000, 32'h0);
      wt(5);
      chk("trip", 32'h0, all_groups_trip);
      wr(12'h000, 32'h1);
      blk(1'b1);
      chk("final", 32'h0, final_trip);
      chk("trip", 32'h0, all_groups_trip);
      blk(1'b0);
      chk("final", 32'h1, final_trip);
      $display("test enable done");
    end
  endtask
  task t_vote;
    begin
      wr(12'h014, 32'h7);
      wr(12'h010, 32'h201);
      wt(2);
      chk("vote", 32'h0, vote_trip);
      st(1, 16'h0065);
      wt(30);
      chk("vote", 32'h1, vote_trip);
      wr(12'h000, 32'h3);
      wr(12'h010, 32'h301);
      wt(5);
      chk("final", 32'h0, final_trip);
      wr(12'h010, 32'h201);
      wt(5);
      chk("final", 32'h1, final_trip);
      wr(12'h010, 32'h200);
      wt(5);
      chk("vote", 32'h0, vote_trip);
      wr(12'h018, 32'h3);
      wr(12'h010, 32'h2202);
      wt(5);
      chk("vote", 32'h2, vote_trip);
      wr(12'h004, 32'h7FFD);
      wt(5);
      chk("vote", 32'h0, vote_trip);
      wr(12'h004, 32'h7FFF);
      wr(12'h000, 32'h1);
      st(0, 16'h0032);
      st(1, 16'h0032);
      wt(30);
      $display("test vote done");
    end
  endtask
  task t_irq;
    begin
      wr(12'h030, 32'h0);
      wr(12'h02C, 32'h7);
      wt(2);
      chk("irq", 32'h0, irq);
      st(2, 16'h0065);
      wt(30);
      chk("irq", 32'h0, irq);
      wr(12'h030, 32'h4);
      wt(2);
      chk("irq", 32'h1, irq);
      wr(12'h02C, 32'h4);
      wt(2);
      chk("irq", 32'h0, irq);
      $display("test irq done");
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    block_trip_cmd = 1'b0;
    num_errors = 0;
    total_checks = 0;
    cyc = 0;
    for (i = 0; i < 11; i = i + 1) model_u.temp_mem[i] = 16'h0032;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_trip;
    t_hyst;
    t_enable;
    t_vote;
    t_irq;
    end_of_test;
  end
endmodule // testbench
